//--- rtl/wake_pkg.sv
// package: register map, field positions, reset values and pattern constants of the wake frame detector
package wake_pkg;
    // printed offsets are register indices; byte address is four times the index
    localparam logic [9:0] IDX_STATION_LO = 10'h010;
    localparam logic [9:0] IDX_STATION_HI = 10'h014;
    localparam logic [9:0] IDX_WAKE_CTRL = 10'h02a;
    localparam logic [9:0] IDX_DEF0 = 10'h030;
    localparam logic [9:0] IDX_DEF1 = 10'h040;
    localparam logic [9:0] IDX_DEF2 = 10'h050;
    localparam logic [9:0] IDX_DEF3 = 10'h060;
    localparam logic [9:0] IDX_DEF_STEP = 10'h004;
    localparam logic [9:0] IDX_IRQ_ENABLE = 10'h090;
    localparam logic [9:0] IDX_IRQ_STATUS = 10'h092;
    localparam logic [9:0] IDX_IRQ_CLEAR = 10'h093;
    localparam logic [9:0] IDX_NOTIFY = 10'h0d4;

    // wake control fields
    localparam int CTRL_REMOTE_EN_BIT = 7;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // interrupt status fields
    localparam int STAT_REMOTE_BIT = 4;
    localparam int STAT_WAKE_BIT = 5;
    localparam logic [15:0] STAT_USED_MASK = 16'h0030;
    localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
    // notify routing fields
    localparam int NOTIFY_IRQ_BIT = 0;
    localparam int NOTIFY_PME_BIT = 1;
    localparam logic [1:0] NOTIFY_RESET = 2'h3;
    localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;

    // frame check
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb_20e3;

    // remote wake pattern
    localparam logic [7:0] SYNC_BYTE = 8'hff;
    localparam logic [2:0] SYNC_LEN = 3'h6;
    localparam logic [2:0] ADDR_BYTES = 3'h6;
    localparam logic [3:0] ADDR_REPS_LAST = 4'hf;
    localparam logic [7:0] MULTICAST_BIT = 8'h01;
endpackage

//--- rtl/crc32_byte.sv
// one byte step of the reflected ethernet crc-32
`timescale 1ns/1ps
module crc32_byte (
    input wire logic [31:0] crc_i,
    input wire logic [7:0] data_i,
    output logic [31:0] crc_o
);
    always_comb begin
        logic [31:0] c;
        c = crc_i;
        for (int i = 0; i < 8; i++) begin
            if (c[0] ^ data_i[i]) begin
                c = (c >> 1) ^ wake_pkg::CRC_POLY;
            end else begin
                c = c >> 1;
            end
        end
        crc_o = c;
    end
endmodule

//--- rtl/remote_wake_scanner.sv
// byte scanner for the sync run followed by sixteen copies of the station address
`timescale 1ns/1ps
module remote_wake_scanner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic valid_i,
    input wire logic [7:0] data_i,
    input wire logic [47:0] station_i,
    output logic hit_o
);
    logic [2:0] sync_r, sync_nxt;
    logic [2:0] pos_r, pos_nxt;
    logic [3:0] rep_r, rep_nxt;
    logic in_addr_r, in_addr_nxt;
    logic found_r, found_nxt;
    logic [7:0] want;

    // first address byte on the wire is the top byte of the station address
    always_comb begin
        want = station_i[47 - 8 * pos_r -: 8];
    end

    always_comb begin
        // partial match is dropped at every frame start
        sync_nxt = start_i ? 3'h0 : sync_r;
        pos_nxt = start_i ? 3'h0 : pos_r;
        rep_nxt = start_i ? 4'h0 : rep_r;
        in_addr_nxt = start_i ? 1'b0 : in_addr_r;
        found_nxt = start_i ? 1'b0 : found_r;
        if (valid_i && !found_nxt) begin
            // searched at every byte position, no fixed offset
            if (in_addr_nxt) begin
                if (data_i == want && !start_i) begin
                    if (pos_nxt == wake_pkg::ADDR_BYTES - 3'h1) begin
                        pos_nxt = 3'h0;
                        if (rep_nxt == wake_pkg::ADDR_REPS_LAST) begin
                            found_nxt = 1'b1;
                            in_addr_nxt = 1'b0;
                        end else begin
                            rep_nxt = rep_nxt + 4'h1;
                        end
                    end else begin
                        pos_nxt = pos_nxt + 3'h1;
                    end
                end else if (data_i == wake_pkg::SYNC_BYTE && pos_nxt == 3'h0 && rep_nxt == 4'h0) begin
                    // a sync run longer than six keeps us waiting for the address
                    in_addr_nxt = 1'b1;
                end else begin
                    // any break restarts the search; an 0xff may open a new run
                    in_addr_nxt = 1'b0;
                    pos_nxt = 3'h0;
                    rep_nxt = 4'h0;
                    sync_nxt = (data_i == wake_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                end
            end else if (data_i == wake_pkg::SYNC_BYTE) begin
                sync_nxt = sync_nxt + 3'h1;
                if (sync_nxt == wake_pkg::SYNC_LEN) begin
                    in_addr_nxt = 1'b1;
                    sync_nxt = 3'h0;
                end
            end else begin
                sync_nxt = 3'h0;
            end
        end
        hit_o = found_nxt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync_r <= 3'h0;
            pos_r <= 3'h0;
            rep_r <= 4'h0;
            in_addr_r <= 1'b0;
            found_r <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            pos_r <= pos_nxt;
            rep_r <= rep_nxt;
            in_addr_r <= in_addr_nxt;
            found_r <= found_nxt;
        end
    end
endmodule

//--- rtl/wake_frame_detector.sv
// wake frame detector: crc-signature wake frames, remote wake pattern, apb registers, events
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module wake_frame_detector #(
    parameter int NUM_WAKE = 4,
    parameter int MASK_BYTES = 64
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic RX_VALID_I,
    input wire logic RX_SOF_I,
    input wire logic RX_EOF_I,
    input wire logic [7:0] RX_DATA_I,
    output logic IRQ_O,
    output logic HOST_IRQ_OUT_N_O,
    output logic POWER_EVENT_OUT_O
);
    if (NUM_WAKE < 1 || NUM_WAKE > 4) begin : g_bad_num
        $error("NUM_WAKE must lie between 1 and 4");
    end
    if (MASK_BYTES < 1 || MASK_BYTES > 64) begin : g_bad_mask
        $error("MASK_BYTES must lie between 1 and 64");
    end

    localparam logic [9:0] DEF_BASE [4] = '{wake_pkg::IDX_DEF0, wake_pkg::IDX_DEF1,
                                            wake_pkg::IDX_DEF2, wake_pkg::IDX_DEF3};

    // ---------------- register state ----------------
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [47:0] station_r, station_nxt;
    logic [15:0] ien_r, ien_nxt;
    logic [15:0] stat_r, stat_nxt;
    logic [1:0] notify_r, notify_nxt;
    logic [31:0] sig_r [NUM_WAKE];
    logic [31:0] sig_nxt [NUM_WAKE];
    logic [63:0] mask_r [NUM_WAKE];
    logic [63:0] mask_nxt [NUM_WAKE];
    logic [31:0] prdata_r, prdata_nxt;

    logic [9:0] idx;
    logic setup, wr_acc, hit;
    logic clr_wr;
    logic [31:0] rd_word;

    // ---------------- frame state ----------------
    logic [31:0] crc_r, crc_nxt, crc_base, crc_step;
    logic [6:0] cnt_r, cnt_nxt, cnt_base;
    logic own_r, own_nxt, bc_r, bc_nxt, mc_r, mc_nxt;
    logic [31:0] wcrc_r [NUM_WAKE];
    logic [31:0] wcrc_nxt [NUM_WAKE];
    logic [31:0] wcrc_step [NUM_WAKE];
    logic [NUM_WAKE-1:0] wmatch;
    logic ev_remote, ev_wake, fcs_ok, dest_ok, pattern_hit, frame_end;
    logic own_b, bc_b;

    assign idx = PADDR_I[11:2];
    assign setup = PSEL_I && !PENABLE_I;
    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
    assign clr_wr = wr_acc && hit && idx == wake_pkg::IDX_IRQ_CLEAR;
    assign frame_end = RX_VALID_I && RX_EOF_I;

    // ---------------- apb decode ----------------
    always_comb begin
        rd_word = 32'h0000_0000;
        hit = 1'b1;
        if (PADDR_I[1:0] != 2'h0) begin
            hit = 1'b0;
        end else if (idx == wake_pkg::IDX_STATION_LO) begin
            rd_word = station_r[31:0];
        end else if (idx == wake_pkg::IDX_STATION_HI) begin
            rd_word = {16'h0000, station_r[47:32]};
        end else if (idx == wake_pkg::IDX_WAKE_CTRL) begin
            rd_word = {16'h0000, ctrl_r};
        end else if (idx == wake_pkg::IDX_IRQ_ENABLE) begin
            rd_word = {16'h0000, ien_r};
        end else if (idx == wake_pkg::IDX_IRQ_STATUS) begin
            rd_word = {16'h0000, stat_r};
        end else if (idx == wake_pkg::IDX_IRQ_CLEAR) begin
            rd_word = 32'h0000_0000;
        end else if (idx == wake_pkg::IDX_NOTIFY) begin
            rd_word = {30'h0, notify_r};
        end else begin
            hit = 1'b0;
            for (int k = 0; k < NUM_WAKE; k++) begin
                if (idx == DEF_BASE[k]) begin
                    hit = 1'b1;
                    rd_word = sig_r[k];
                end else if (idx == DEF_BASE[k] + wake_pkg::IDX_DEF_STEP) begin
                    hit = 1'b1;
                    rd_word = mask_r[k][31:0];
                end else if (idx == DEF_BASE[k] + 10'(2 * wake_pkg::IDX_DEF_STEP)) begin
                    hit = 1'b1;
                    rd_word = mask_r[k][63:32];
                end
            end
        end
    end

    // zero wait state: read data is captured in the setup cycle
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;
    assign PRDATA_O = prdata_r;

    // read data is fetched in the setup cycle so the access phase needs no wait state
    always_comb begin
        prdata_nxt = setup ? (PWRITE_I ? 32'h0000_0000 : rd_word) : prdata_r;
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        station_nxt = station_r;
        ien_nxt = ien_r;
        notify_nxt = notify_r;
        for (int k = 0; k < NUM_WAKE; k++) begin
            sig_nxt[k] = sig_r[k];
            mask_nxt[k] = mask_r[k];
        end
        if (wr_acc && hit && PADDR_I[1:0] == 2'h0) begin
            if (idx == wake_pkg::IDX_STATION_LO) begin
                station_nxt[31:0] = PWDATA_I;
            end
            if (idx == wake_pkg::IDX_STATION_HI) begin
                station_nxt[47:32] = PWDATA_I[15:0];
            end
            if (idx == wake_pkg::IDX_WAKE_CTRL) begin
                ctrl_nxt = PWDATA_I[15:0];
            end
            if (idx == wake_pkg::IDX_IRQ_ENABLE) begin
                ien_nxt = PWDATA_I[15:0] & wake_pkg::STAT_USED_MASK;
            end
            if (idx == wake_pkg::IDX_NOTIFY) begin
                notify_nxt = PWDATA_I[1:0];
            end
            for (int k = 0; k < NUM_WAKE; k++) begin
                // definition block: signature, then byte mask low and high
                if (idx == DEF_BASE[k]) begin
                    sig_nxt[k] = PWDATA_I;
                end
                if (idx == DEF_BASE[k] + wake_pkg::IDX_DEF_STEP) begin
                    mask_nxt[k][31:0] = PWDATA_I;
                end
                if (idx == DEF_BASE[k] + 10'(2 * wake_pkg::IDX_DEF_STEP)) begin
                    mask_nxt[k][63:32] = PWDATA_I;
                end
            end
        end
    end

    // ---------------- receive path ----------------
    // a start byte begins a fresh frame even if the previous one never ended
    assign crc_base = RX_SOF_I ? wake_pkg::CRC_INIT : crc_r;
    assign cnt_base = RX_SOF_I ? 7'h00 : cnt_r;

    crc32_byte u_fcs (
        .crc_i(crc_base),
        .data_i(RX_DATA_I),
        .crc_o(crc_step)
    );

    for (genvar k = 0; k < NUM_WAKE; k++) begin : g_wake
        logic [31:0] wbase;
        logic use_byte;
        assign wbase = RX_SOF_I ? wake_pkg::CRC_INIT : wcrc_r[k];
        // only masked bytes within the first MASK_BYTES feed the signature
        assign use_byte = (cnt_base < 7'(MASK_BYTES)) && mask_r[k][cnt_base[5:0]];
        crc32_byte u_sig (
            .crc_i(wbase),
            .data_i(RX_DATA_I),
            .crc_o(wcrc_step[k])
        );
        assign wcrc_nxt[k] = !RX_VALID_I ? wcrc_r[k] : (use_byte ? wcrc_step[k] : wbase);
        // each type is only recognised while its own enable bit is set
        assign wmatch[k] = ctrl_r[k] && (~wcrc_nxt[k] == sig_r[k]);
    end

    remote_wake_scanner u_scan (
        .clk_i(REF_CLK_I),
        .rst_i(RST_I),
        .start_i(RX_VALID_I && RX_SOF_I),
        .valid_i(RX_VALID_I),
        .data_i(RX_DATA_I),
        .station_i(station_r),
        .hit_o(pattern_hit)
    );

    // running frame check and byte position; the count saturates on long frames
    always_comb begin
        crc_nxt = RX_VALID_I ? crc_step : crc_r;
        cnt_nxt = cnt_r;
        if (RX_VALID_I) begin
            if (cnt_base != 7'h7f) begin
                cnt_nxt = cnt_base + 7'h01;
            end else begin
                cnt_nxt = cnt_base;
            end
        end
    end

    // destination check over the first six bytes
    always_comb begin
        // explicit byte pick keeps the select inside the station word past the address field
        case (cnt_base[2:0])
            3'h0: own_b = RX_DATA_I == station_r[47:40];
            3'h1: own_b = RX_DATA_I == station_r[39:32];
            3'h2: own_b = RX_DATA_I == station_r[31:24];
            3'h3: own_b = RX_DATA_I == station_r[23:16];
            3'h4: own_b = RX_DATA_I == station_r[15:8];
            3'h5: own_b = RX_DATA_I == station_r[7:0];
            default: own_b = 1'b0;
        endcase
        bc_b = RX_DATA_I == wake_pkg::SYNC_BYTE;
        own_nxt = RX_SOF_I ? 1'b1 : own_r;
        bc_nxt = RX_SOF_I ? 1'b1 : bc_r;
        mc_nxt = RX_SOF_I ? 1'b0 : mc_r;
        if (RX_VALID_I && cnt_base < 7'(wake_pkg::ADDR_BYTES)) begin
            own_nxt = own_nxt && own_b;
            bc_nxt = bc_nxt && bc_b;
            if (cnt_base == 7'h00) begin
                mc_nxt = (RX_DATA_I & wake_pkg::MULTICAST_BIT) != 8'h00;
            end
        end
    end

    // broadcast and multicast pass too; the pattern itself must carry our address
    assign dest_ok = own_nxt || bc_nxt || mc_nxt;
    assign fcs_ok = crc_step == wake_pkg::CRC_RESIDUE;
    // no protocol checks: pattern, valid frame, accepted destination and the remote enable bit are all needed
    assign ev_remote = frame_end && fcs_ok && dest_ok && ctrl_r[wake_pkg::CTRL_REMOTE_EN_BIT]
                       && pattern_hit;
    assign ev_wake = frame_end && fcs_ok && (|wmatch);

    // ---------------- status and notify ----------------
    always_comb begin
        stat_nxt = stat_r;
        if (clr_wr) begin
            stat_nxt = stat_nxt & ~PWDATA_I[15:0];
        end
        // a new event beats a clear written in the same cycle
        if (ev_remote) begin
            stat_nxt[wake_pkg::STAT_REMOTE_BIT] = 1'b1;
        end
        if (ev_wake) begin
            stat_nxt[wake_pkg::STAT_WAKE_BIT] = 1'b1;
        end
    end

    assign IRQ_O = |(stat_r & ien_r);
    // routing lets software pick the host line, the power event, or both
    assign HOST_IRQ_OUT_N_O = !(IRQ_O && notify_r[wake_pkg::NOTIFY_IRQ_BIT]);
    // power event is not gated by the interrupt enable so it works with the host asleep
    assign POWER_EVENT_OUT_O = notify_r[wake_pkg::NOTIFY_PME_BIT]
                               && (|(stat_r & wake_pkg::STAT_USED_MASK));

    // ---------------- registers ----------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            ctrl_r <= wake_pkg::CTRL_RESET;
            station_r <= wake_pkg::STATION_RESET;
            ien_r <= wake_pkg::IRQ_ENABLE_RESET;
            notify_r <= wake_pkg::NOTIFY_RESET;
            for (int k = 0; k < NUM_WAKE; k++) begin
                sig_r[k] <= 32'h0000_0000;
                mask_r[k] <= 64'h0000_0000_0000_0000;
            end
        end else begin
            ctrl_r <= ctrl_nxt;
            station_r <= station_nxt;
            ien_r <= ien_nxt;
            notify_r <= notify_nxt;
            for (int k = 0; k < NUM_WAKE; k++) begin
                sig_r[k] <= sig_nxt[k];
                mask_r[k] <= mask_nxt[k];
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            prdata_r <= 32'h0000_0000;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    // sticky status kept apart from the configuration so a clear never touches setup
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            stat_r <= 16'h0000;
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // frame state: running check values, byte position and destination flags
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            crc_r <= wake_pkg::CRC_INIT;
            cnt_r <= 7'h00;
            own_r <= 1'b0;
            bc_r <= 1'b0;
            mc_r <= 1'b0;
            for (int k = 0; k < NUM_WAKE; k++) begin
                wcrc_r[k] <= wake_pkg::CRC_INIT;
            end
        end else begin
            crc_r <= crc_nxt;
            cnt_r <= cnt_nxt;
            own_r <= own_nxt;
            bc_r <= bc_nxt;
            mc_r <= mc_nxt;
            for (int k = 0; k < NUM_WAKE; k++) begin
                wcrc_r[k] <= wcrc_nxt[k];
            end
        end
    end
endmodule

//--- testbench/wake_frame_detector_assertions.sv
// checker: port-level timing properties of the wake frame detector
`timescale 1ns/1ps
module wake_frame_detector_assertions (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic RX_VALID_I,
    input wire logic RX_EOF_I,
    input wire logic IRQ_O,
    input wire logic HOST_IRQ_OUT_N_O,
    input wire logic POWER_EVENT_OUT_O
);
    logic acc;
    logic eof;
    assign acc = PSEL_I && PENABLE_I;
    assign eof = RX_VALID_I && RX_EOF_I;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);
    AST_READY: assert property (acc |-> PREADY_O) else $error("no ready in access");
    AST_ERR_PHASE: assert property (PSLVERR_O |-> acc) else $error("error outside access");
    AST_CTRL_MAPPED: assert property (acc && PADDR_I == 12'h0a8 |-> !PSLVERR_O)
        else $error("control refused");
    AST_ERR_ZERO: assert property (acc && !PWRITE_I && PSLVERR_O |-> PRDATA_O == 32'h0)
        else $error("refused read not zero");
    AST_IRQ_N: assert property (!HOST_IRQ_OUT_N_O |-> IRQ_O) else $error("host irq without cause");
    AST_PME_CAUSE: assert property ($rose(POWER_EVENT_OUT_O) |->
        $past(eof) || $past(eof, 2) || $past(acc && PWRITE_I)) else $error("power event without frame end");
    AST_IRQ_CAUSE: assert property ($rose(IRQ_O) |->
        $past(eof) || $past(eof, 2) || $past(acc && PWRITE_I)) else $error("irq without frame end");
    AST_PME_STICKY: assert property ($fell(POWER_EVENT_OUT_O) |-> $past(acc && PWRITE_I))
        else $error("power event dropped by itself");
    AST_RESET_OUT: assert property (disable iff (1'b0) RST_I |=>
        !IRQ_O && HOST_IRQ_OUT_N_O && !POWER_EVENT_OUT_O) else $error("outputs active after reset");
endmodule

bind wake_frame_detector wake_frame_detector_assertions chk_u (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .RX_VALID_I(RX_VALID_I), .RX_EOF_I(RX_EOF_I),
    .IRQ_O(IRQ_O), .HOST_IRQ_OUT_N_O(HOST_IRQ_OUT_N_O), .POWER_EVENT_OUT_O(POWER_EVENT_OUT_O));

//--- testbench/mac_rx_model.sv
// byte source standing in for the mac receive path
`timescale 1ns/1ps
module mac_rx_model (
    input wire logic clk_i,
    output logic valid_o,
    output logic sof_o,
    output logic eof_o,
    output logic [7:0] data_o
);
    initial begin
        valid_o = 1'b0;
        sof_o = 1'b0;
        eof_o = 1'b0;
        data_o = 8'h5a;
    end
    function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
        logic [31:0] c;
        c = wake_pkg::CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {24'h0, q[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ wake_pkg::CRC_POLY) : (c >> 1);
        end
        return ~c;
    endfunction
    // frames go out whole with their check sequence; bad corrupts it
    task automatic send(input logic [7:0] q[$], input logic bad);
        logic [31:0] f;
        f = crc_of(q) ^ {32{bad}};
        for (int i = 0; i < 4; i++) q.push_back(f[8*i +: 8]);
        foreach (q[i]) begin
            @(posedge clk_i);
            valid_o <= 1'b1;
            sof_o <= (i == 0);
            eof_o <= (i == q.size() - 1);
            data_o <= q[i];
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        sof_o <= 1'b0;
        eof_o <= 1'b0;
        // an idle lane must not keep showing the last byte
        data_o <= ~data_o;
    endtask
endmodule

//--- testbench/tb.sv
// self-checking bench of the wake frame detector
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [7:0] ctrl; logic [1:0] kind; logic [1:0] k; logic [1:0] dest;
        logic bad; logic [7:0] exp;} row_t;
    localparam logic [47:0] ST = 48'h1122_3344_5566;
    logic clk, rst, psel, pen, pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, er, rxv, rxs, rxe, irq, hirq_n, power_event_out;
    logic [7:0] rxd;
    logic [7:0] frm[$];
    int err_count = 0;
    int tests_run = 0;
    // kind 0 wake frame k, 1 remote pattern, 2 broken copy, 3 short sync; dest 0 own, 1 bcast, 2 other, 3 mcast
    row_t rows [14] = '{
        '{8'h01, 2'd0, 2'd0, 2'd0, 1'b0, 8'h20}, '{8'h02, 2'd0, 2'd1, 2'd0, 1'b0, 8'h20},
        '{8'h04, 2'd0, 2'd2, 2'd0, 1'b0, 8'h20}, '{8'h08, 2'd0, 2'd3, 2'd0, 1'b0, 8'h20},
        '{8'h0b, 2'd0, 2'd2, 2'd0, 1'b0, 8'h00}, '{8'h02, 2'd0, 2'd1, 2'd0, 1'b1, 8'h00},
        '{8'h80, 2'd1, 2'd0, 2'd0, 1'b0, 8'h10}, '{8'h80, 2'd1, 2'd0, 2'd1, 1'b0, 8'h10},
        '{8'h7f, 2'd1, 2'd0, 2'd0, 1'b0, 8'h00}, '{8'h80, 2'd2, 2'd0, 2'd0, 1'b0, 8'h00},
        '{8'h80, 2'd3, 2'd0, 2'd0, 1'b0, 8'h00}, '{8'h80, 2'd1, 2'd0, 2'd0, 1'b1, 8'h00},
        '{8'h80, 2'd1, 2'd0, 2'd2, 1'b0, 8'h00}, '{8'h80, 2'd1, 2'd0, 2'd3, 1'b0, 8'h10}};
    logic [9:0] defs [4] = '{wake_pkg::IDX_DEF0, wake_pkg::IDX_DEF1, wake_pkg::IDX_DEF2, wake_pkg::IDX_DEF3};
    logic [11:0] ra [4] = '{12'h0a8, 12'h240, 12'h248, 12'h350};
    logic [31:0] rv [4] = '{32'h0, 32'h0, 32'h0, 32'h3};

    wake_frame_detector dut_u (.REF_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RX_VALID_I(rxv), .RX_SOF_I(rxs), .RX_EOF_I(rxe), .RX_DATA_I(rxd), .IRQ_O(irq),
        .HOST_IRQ_OUT_N_O(hirq_n), .POWER_EVENT_OUT_O(power_event_out));
    mac_rx_model mac_u (.clk_i(clk), .valid_o(rxv), .sof_o(rxs), .eof_o(rxe), .data_o(rxd));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic build(input row_t r);
        frm = {};
        for (int i = 0; i < 6; i++)
            frm.push_back(r.dest == 1 ? 8'hff : r.dest == 2 ? 8'h02 : r.dest == 3 ? 8'h01 : ST[47-8*i -: 8]);
        for (int i = 0; i < 6; i++) frm.push_back(8'h20 + 8'(i));
        if (r.kind == 0) begin
            for (int i = 0; i < 46; i++) frm.push_back(i == r.k + 2 ? 8'ha0 + 8'(r.k) : 8'h00);
        end else begin
            frm.push_back(8'h08);
            frm.push_back(8'h42);
            frm.push_back(r.kind == 3 ? 8'h00 : 8'hff);
            for (int i = 0; i < (r.kind == 3 ? 5 : 6); i++) frm.push_back(8'hff);
            for (int c = 0; c < 16; c++)
                for (int i = 0; i < 6; i++) frm.push_back((r.kind == 2 && c == 15 && i == 5) ? 8'h67 : ST[47-8*i -: 8]);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic frame(input row_t r);
        build(r);
        mac_u.send(frm, r.bad);
        repeat (3) @(posedge clk);
    endtask
    initial begin
        rst = 1'b1;
        {psel, pen, pwr, paddr, pwdata} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(1'b1, 12'h050, 32'h1122);
        apb(1'b1, 12'h040, 32'h3344_5566);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, {defs[k], 2'b00}, mac_u.crc_of('{8'ha0 + 8'(k)}));
            apb(1'b1, {defs[k] + wake_pkg::IDX_DEF_STEP, 2'b00}, 32'h1 << (14 + k));
        end
        // rows: each wake frame alone, disabled, bad check, remote pattern variants all at offset 14 after the type bytes
        foreach (rows[i]) begin
            apb(1'b1, 12'h24c, 32'h30);
            apb(1'b1, 12'h0a8, {24'h0, rows[i].ctrl});
            frame(rows[i]);
            apb(1'b0, 12'h248, 32'h0);
            chk(rd, {24'h0, rows[i].exp});
            chk({31'h0, power_event_out}, {31'h0, rows[i].exp != 8'h0});
        end
        apb(1'b1, 12'h24c, 32'h30);
        apb(1'b1, 12'h240, 32'h10);
        frame(rows[6]);
        chk({29'h0, irq, hirq_n, power_event_out}, 32'h5);
        apb(1'b1, 12'h248, 32'h0);
        apb(1'b0, 12'h248, 32'h0);
        chk(rd, 32'h10);
        apb(1'b1, 12'h240, 32'h0);
        @(negedge clk);
        chk({30'h0, irq, hirq_n}, 32'h1);
        apb(1'b1, 12'h350, 32'h0);
        apb(1'b1, 12'h240, 32'h10);
        @(negedge clk);
        chk({29'h0, irq, hirq_n, power_event_out}, 32'h6);
        apb(1'b1, 12'h24c, 32'h10);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, 12'h3fc, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ra[i], 32'h0);
            chk(rd, rv[i]);
        end
        wrap_up;
    end
    initial begin
        #(100 * 40000);
        err_count++;
        wrap_up;
    end
endmodule
